// ==== rtl/slm_mode_select.sv ====
/*
 * Output mode selector of the video-to-serial bridge: holds the port
 * select, receiver capability and link control registers, picks single,
 * dual or replicate operation and steers pixels to the two ports.
 * Assumes a register port fed by the control bus slave on i_clk, a
 * frequency meter on i_clk, and receiver detect levels from the link side.
 */
`timescale 1ns/1ps
`include "slm_regs.svh"
module slm_mode_select
    import slm_pkg::*;
(
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // Register port
    input wire logic i_reg_wr,
    input wire logic i_reg_rd,
    input wire logic [7:0] i_reg_addr,
    input wire logic [7:0] i_reg_wdata,
    output logic [7:0] o_reg_rdata,
    output logic o_reg_rvalid,
    // Downstream detect, from the link side
    input wire logic [1:0] i_rx_present,
    input wire logic [1:0] i_rx_dual_cap,
    // Measured input pixel clock, whole MHz
    input wire logic [7:0] i_pclk_mhz,
    // Video in
    input wire logic i_frame_start,
    input wire logic i_pix_valid,
    input wire logic [23:0] i_pix_data,
    // Serial ports out
    output logic [1:0] o_port_valid,
    output logic [23:0] o_port0_data,
    output logic [23:0] o_port1_data,
    output logic o_port1_phy_en,
    output logic o_port1_bc_en,
    // Status
    output logic o_pll_reset,
    output logic [2:0] o_mode
);
    slm_top_s q;
    slm_top_s d;
    slm_mode_e target;
    slm_mode_e applied;
    logic [2:0] ctl_mode;
    logic force_dual;
    logic no_dual;
    logic [1:0] present;
    logic [1:0] dual_cap;
    logic p1_dual_eff;
    logic sel_p1;

    slm_pix_if pix ();

    assign ctl_mode = q.link_ctl[`SLM_CTL_MODE_HI:`SLM_CTL_MODE_LO];
    assign force_dual = (ctl_mode == `SLM_CTL_FORCE_DUAL);
    assign no_dual = (ctl_mode == `SLM_CTL_NO_DUAL);
    assign present = q.sync2[1:0];
    assign dual_cap = q.sync2[3:2];
    assign sel_p1 = (q.port_sel == `SLM_PORT_SEL_P1);
    // Software override lets port 1 count as dual capable without detection
    assign p1_dual_eff = dual_cap[1] | q.cap[1][`SLM_CAP_DUAL_BIT];

    // Mode the links would run in, recomputed every cycle
    always_comb begin
        target = SLM_IDLE;
        if (force_dual) begin
            target = SLM_DUAL;
        end else if (present == 2'b00) begin
            target = SLM_IDLE;
        end else if (present == 2'b01) begin
            target = SLM_SINGLE0;
        end else if (present == 2'b10) begin
            // Forced single shuts the secondary link, so nothing can be sent
            target = no_dual ? SLM_IDLE : SLM_SINGLE1;
        end else if (no_dual) begin
            target = SLM_SINGLE0;
        end else if (dual_cap[0] && p1_dual_eff) begin
            // One dual-capable receiver on both ports
            target = (i_pclk_mhz > `SLM_SINGLE_MAX_MHZ) ? SLM_DUAL : SLM_SINGLE0;
        end else begin
            // Two independent receivers
            target = (i_pclk_mhz <= `SLM_REPL_MAX_MHZ) ? SLM_REPLICATE : SLM_SINGLE0;
        end
    end

    // The new mode is adopted on the first pixel of a frame only
    assign applied = i_frame_start ? target : q.mode;

    always_comb begin
        d = q;
        d.sync1 = {i_rx_dual_cap, i_rx_present};
        d.sync2 = q.sync1;
        d.mode = applied;
        d.freq_prev = i_pclk_mhz;
        // Zero means no reading yet, so leaving reset is no change; a clock
        // starting from a zero reading therefore does not reset the PLL
        d.pll_reset = q.link_ctl[`SLM_CTL_PLLRST_BIT] && (q.freq_prev != 8'h00)
            && (i_pclk_mhz != q.freq_prev);
        d.port1_en = !no_dual;
        d.rvalid = i_reg_rd;
        if (i_reg_wr) begin
            unique case (i_reg_addr)
                `SLM_ADDR_PORT_SEL: d.port_sel = i_reg_wdata;
                `SLM_ADDR_RX_CAP: d.cap[sel_p1] = i_reg_wdata;
                `SLM_ADDR_LINK_CTL: d.link_ctl = i_reg_wdata;
                default: d.port_sel = q.port_sel;
            endcase
        end
        if (i_reg_rd) begin
            unique case (i_reg_addr)
                `SLM_ADDR_PORT_SEL: d.rdata = q.port_sel;
                `SLM_ADDR_RX_CAP: d.rdata = q.cap[sel_p1];
                `SLM_ADDR_LINK_CTL: d.rdata = q.link_ctl;
                `SLM_ADDR_STATUS: d.rdata = {2'b00, present, dual_cap[0], q.mode};
                default: d.rdata = 8'h00;
            endcase
        end else begin
            d.rdata = 8'h00;
        end
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            q.port_sel <= `SLM_PORT_SEL_RST;
            q.cap <= {`SLM_RX_CAP_RST, `SLM_RX_CAP_RST};
            q.link_ctl <= `SLM_LINK_CTL_RST;
            q.sync1 <= 4'h0;
            q.sync2 <= 4'h0;
            q.freq_prev <= 8'h00;
            q.mode <= SLM_IDLE;
            q.pll_reset <= 1'b0;
            q.port1_en <= 1'b1;
            q.rdata <= 8'h00;
            q.rvalid <= 1'b0;
        end else begin
            q <= d;
        end
    end

    assign pix.mode = applied;
    assign pix.frame_start = i_frame_start;
    assign pix.pix_valid = i_pix_valid;
    assign pix.pix_data = i_pix_data;

    slm_pixel_split u_split (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .pix(pix),
        .o_valid(o_port_valid),
        .o_data0(o_port0_data),
        .o_data1(o_port1_data)
    );

    assign o_reg_rdata = q.rdata;
    assign o_reg_rvalid = q.rvalid;
    assign o_port1_phy_en = q.port1_en;
    assign o_port1_bc_en = q.port1_en;
    assign o_pll_reset = q.pll_reset;
    assign o_mode = q.mode;
endmodule

// ==== inc/slm_regs.svh ====
/*
 * Register offsets, field positions, reset values and thresholds of the
 * serial link mode selector. Definitions only; included by bare name.
 */
`ifndef SLM_REGS_SVH
`define SLM_REGS_SVH

`define SLM_ADDR_PORT_SEL   8'h1E
`define SLM_ADDR_RX_CAP     8'h20
`define SLM_ADDR_LINK_CTL   8'h5B
`define SLM_ADDR_STATUS     8'h5D

`define SLM_PORT_SEL_RST    8'h01
`define SLM_PORT_SEL_P0     8'h01
`define SLM_PORT_SEL_P1     8'h02
`define SLM_RX_CAP_RST      8'h00
`define SLM_LINK_CTL_RST    8'h20

`define SLM_CAP_DUAL_BIT    7
`define SLM_CTL_PLLRST_BIT  5
`define SLM_CTL_MODE_HI     2
`define SLM_CTL_MODE_LO     0
`define SLM_CTL_FORCE_DUAL  3'h3
`define SLM_CTL_NO_DUAL     3'h4

`define SLM_SINGLE_MAX_MHZ  8'h60
`define SLM_REPL_MAX_MHZ    8'h69

`endif

// ==== inc/slm_pkg.sv ====
/*
 * Types shared by the mode selector and its pixel splitter.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package slm_pkg;
    typedef enum logic [2:0] {
        SLM_IDLE,
        SLM_SINGLE0,
        SLM_SINGLE1,
        SLM_DUAL,
        SLM_REPLICATE
    } slm_mode_e;

    typedef logic [23:0] slm_pix_t;

    typedef struct packed {
        logic [1:0] valid;
        slm_pix_t data0;
        slm_pix_t data1;
        logic phase;
    } slm_split_s;

    typedef struct packed {
        logic [7:0] port_sel;
        logic [1:0][7:0] cap;
        logic [7:0] link_ctl;
        logic [3:0] sync1;
        logic [3:0] sync2;
        logic [7:0] freq_prev;
        slm_mode_e mode;
        logic pll_reset;
        logic port1_en;
        logic [7:0] rdata;
        logic rvalid;
    } slm_top_s;
endpackage

// ==== inc/slm_pix_if.sv ====
/*
 * Carries the applied mode and the pixel stream from the mode selector to
 * the splitter. Both ends share one clock.
 */
`timescale 1ns/1ps
interface slm_pix_if;
    import slm_pkg::*;
    slm_mode_e mode;
    logic frame_start;
    logic pix_valid;
    slm_pix_t pix_data;

    modport src (output mode, output frame_start, output pix_valid, output pix_data);
    modport snk (input mode, input frame_start, input pix_valid, input pix_data);
endinterface

// ==== rtl/slm_pixel_split.sv ====
/*
 * Distributes the pixel stream onto the two serial ports by mode.
 * Assumes the mode on the interface only changes at a frame start.
 */
`timescale 1ns/1ps
module slm_pixel_split
    import slm_pkg::*;
(
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // Stream in
    slm_pix_if.snk pix,
    // Ports out
    output logic [1:0] o_valid,
    output slm_pix_t o_data0,
    output slm_pix_t o_data1
);
    slm_split_s q;
    slm_split_s d;
    logic [1:0] take;

    always_comb begin
        take = 2'b00;
        unique case (pix.mode)
            SLM_IDLE: take = 2'b00;
            SLM_SINGLE0: take = 2'b01;
            SLM_SINGLE1: take = 2'b10;
            // Frame start realigns the phase so pixel 0 always lands on port 0
            SLM_DUAL: take = (pix.frame_start || !q.phase) ? 2'b01 : 2'b10;
            SLM_REPLICATE: take = 2'b11;
        endcase
        d = q;
        d.valid = pix.pix_valid ? take : 2'b00;
        if (pix.pix_valid && take[0]) begin
            d.data0 = pix.pix_data;
        end
        if (pix.pix_valid && take[1]) begin
            d.data1 = pix.pix_data;
        end
        if (pix.pix_valid) begin
            d.phase = (pix.mode == SLM_DUAL) ? take[0] : 1'b0;
        end else if (pix.frame_start) begin
            d.phase = 1'b0;
        end
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign o_valid = q.valid;
    assign o_data0 = q.data0;
    assign o_data1 = q.data1;
endmodule

// ==== dv/slm_rx_model.sv ====
/* Behavioural model of the receivers on the two serial ports.
   Assumes the bench chooses which receivers are attached and clears the counts. */
`timescale 1ns/1ps
module slm_rx_model (
    // Clock and bench control
    input wire logic i_clk,
    input wire logic i_clr,
    input wire logic [1:0] i_attach,
    input wire logic [1:0] i_dual,
    // Ports from the bridge
    input wire logic [1:0] i_valid,
    // Detect levels and pixel counts
    output logic [1:0] o_present,
    output logic [1:0] o_dual_cap,
    output logic [7:0] o_cnt0,
    output logic [7:0] o_cnt1
);
    // A missing receiver reports nothing and sees no pixels
    assign o_present = i_attach;
    assign o_dual_cap = i_dual & i_attach;
    always @(posedge i_clk) begin
        if (i_clr) begin
            o_cnt0 <= 8'h00;
            o_cnt1 <= 8'h00;
        end else begin
            o_cnt0 <= o_cnt0 + 8'(i_valid[0] & i_attach[0]);
            o_cnt1 <= o_cnt1 + 8'(i_valid[1] & i_attach[1]);
        end
    end
endmodule

// ==== dv/slm_mode_select_monitor.sv ====
/* Port checker of the link mode selector.
   Assumes one clock domain; attached by the bind at the foot. */
`timescale 1ns/1ps
module slm_mode_select_monitor (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // Register port
    input wire logic i_reg_wr,
    input wire logic i_reg_rd,
    input wire logic [7:0] i_reg_addr,
    input wire logic [7:0] i_reg_wdata,
    input wire logic [7:0] o_reg_rdata,
    input wire logic o_reg_rvalid,
    // Stream and status
    input wire logic i_frame_start,
    input wire logic [7:0] i_pclk_mhz,
    input wire logic [1:0] o_port_valid,
    input wire logic [23:0] o_port0_data,
    input wire logic [23:0] o_port1_data,
    input wire logic o_port1_phy_en,
    input wire logic o_pll_reset,
    input wire logic [2:0] o_mode
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);
    a_read_answer: assert property (i_reg_rd |=> o_reg_rvalid)
        else $error("read not answered");
    a_rdata_quiet: assert property (!o_reg_rvalid |-> o_reg_rdata == 8'h00)
        else $error("read data outside answer");
    a_idle_quiet: assert property (o_mode == 3'h0 |-> o_port_valid == 2'b00)
        else $error("video sent while idle");
    a_repl_same: assert property (o_mode == 3'h4 && o_port_valid != 2'b00 |->
        o_port_valid == 2'b11 && o_port0_data == o_port1_data) else $error("copies differ");
    a_dual_split: assert property (o_mode == 3'h3 |-> o_port_valid != 2'b11)
        else $error("pixel on both ports in dual");
    a_first_only: assert property (o_mode == 3'h1 |-> !o_port_valid[1])
        else $error("secondary used in single");
    a_second_only: assert property (o_mode == 3'h2 |-> !o_port_valid[0])
        else $error("primary used in secondary mode");
    a_mode_frame: assert property (!i_frame_start |=> $stable(o_mode))
        else $error("mode changed mid frame");
    a_pll_cause: assert property (o_pll_reset |-> $past(i_pclk_mhz) != $past(i_pclk_mhz, 2))
        else $error("pll reset without change");
    a_phy_off: assert property (i_reg_wr && i_reg_addr == 8'h5B &&
        i_reg_wdata[2:0] == 3'h4 |-> ##[1:2] !o_port1_phy_en) else $error("phy kept on");
    c_dual: cover property (o_mode == 3'h3 && o_port_valid == 2'b10);
    c_repl: cover property (o_mode == 3'h4 && o_port_valid == 2'b11);
    c_pll: cover property (o_pll_reset);
endmodule
bind slm_mode_select slm_mode_select_monitor u_mon (.i_clk, .i_rst, .i_reg_wr, .i_reg_rd,
    .i_reg_addr, .i_reg_wdata, .o_reg_rdata, .o_reg_rvalid, .i_frame_start, .i_pclk_mhz,
    .o_port_valid, .o_port0_data, .o_port1_data, .o_port1_phy_en, .o_pll_reset, .o_mode);

// ==== dv/test_serial_link_mode_select.sv ====
/* Self-checking bench of the link mode selector with the receiver model.
   Assumes the selector's register port timing and a 25 MHz clock. */
`timescale 1ns/1ps
module test_serial_link_mode_select;
    logic i_clk = 1'b0;
    logic i_rst = 1'b1;
    logic wr = 1'b0, rd = 1'b0, fs = 1'b0, pv = 1'b0, clr = 1'b0;
    logic [7:0] addr = 8'h00, wdata = 8'h00, pclk = 8'h32, rdata, c0, c1;
    logic [23:0] pix = 24'h00_0000, d0, d1;
    logic [1:0] att = 2'b00, dcap = 2'b00, pres, dual, pvld;
    logic rvalid, phy, bc, pll;
    logic [2:0] mode, last_m = 3'h0;
    int errors = 0, compares = 0;

    always #20 i_clk = ~i_clk;

    slm_mode_select dut (.i_clk(i_clk), .i_rst(i_rst), .i_reg_wr(wr), .i_reg_rd(rd),
        .i_reg_addr(addr), .i_reg_wdata(wdata), .o_reg_rdata(rdata), .o_reg_rvalid(rvalid),
        .i_rx_present(pres), .i_rx_dual_cap(dual), .i_pclk_mhz(pclk), .i_frame_start(fs),
        .i_pix_valid(pv), .i_pix_data(pix), .o_port_valid(pvld), .o_port0_data(d0),
        .o_port1_data(d1), .o_port1_phy_en(phy), .o_port1_bc_en(bc), .o_pll_reset(pll),
        .o_mode(mode));
    slm_rx_model u_rx (.i_clk(i_clk), .i_clr(clr), .i_attach(att), .i_dual(dcap),
        .i_valid(pvld), .o_present(pres), .o_dual_cap(dual), .o_cnt0(c0), .o_cnt1(c1));

    task automatic give_verdict();
        if (errors == 0 && compares > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    task automatic check(input logic [23:0] seen, input logic [23:0] exp);
        compares++;
        if (seen !== exp) begin
            errors++;
            $display("ERROR %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge i_clk);
        #1;
    endtask
    // Strobes drop for a cycle so back-to-back calls never reassign in one step
    task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
        addr = a; wdata = d; wr = 1'b1; step(1);
        wr = 1'b0; step(1);
    endtask
    task automatic reg_rd(input logic [7:0] a, input logic [7:0] exp);
        addr = a; rd = 1'b1; step(1);
        rd = 1'b0;
        check(24'({rvalid, rdata}), 24'({1'b1, exp}));
        step(1);
    endtask
    task automatic auto_case(input logic [1:0] a, input logic [1:0] d, input logic [7:0] f,
        input logic [2:0] m, input logic [7:0] n0, input logic [7:0] n1);
        att = a; dcap = d; pclk = f; step(4);
        check(24'(mode), 24'(last_m));
        clr = 1'b1; step(1);
        clr = 1'b0;
        for (int i = 0; i < 4; i++) begin
            fs = (i == 0); pv = 1'b1; pix = pix + 24'h00_0001; step(1);
        end
        pv = 1'b0; step(2);
        check(24'(mode), 24'(m));
        check(24'(c0), 24'(n0));
        check(24'(c1), 24'(n1));
        if (n0 != 8'h00) check(d0, (n0 == 8'h02) ? pix - 24'h00_0001 : pix);
        if (n1 != 8'h00) check(d1, pix);
        last_m = m;
    endtask
    task automatic pll_probe(input logic [7:0] f, input logic exp);
        logic seen;
        seen = 1'b0; pclk = f;
        repeat (3) begin
            step(1);
            seen = seen | pll;
        end
        check(24'(seen), 24'(exp));
    endtask

    initial begin
        #2_000_000;
        errors++;
        give_verdict();
    end
    initial begin
        repeat (3) @(posedge i_clk);
        #1 i_rst = 1'b0;
        step(1);
        reg_rd(8'h1E, 8'h01);
        reg_rd(8'h20, 8'h00);
        reg_rd(8'h5B, 8'h20);
        reg_rd(8'h10, 8'h00);
        auto_case(2'b00, 2'b00, 8'h32, 3'h0, 8'h00, 8'h00);
        auto_case(2'b01, 2'b00, 8'h32, 3'h1, 8'h04, 8'h00);
        auto_case(2'b10, 2'b00, 8'h32, 3'h2, 8'h00, 8'h04);
        auto_case(2'b11, 2'b00, 8'h32, 3'h4, 8'h04, 8'h04);
        auto_case(2'b11, 2'b00, 8'h6A, 3'h1, 8'h04, 8'h00);
        auto_case(2'b11, 2'b00, 8'h69, 3'h4, 8'h04, 8'h04);
        auto_case(2'b11, 2'b11, 8'h61, 3'h3, 8'h02, 8'h02);
        auto_case(2'b11, 2'b11, 8'h60, 3'h1, 8'h04, 8'h00);
        reg_wr(8'h1E, 8'h02);
        reg_wr(8'h20, 8'h8F);
        reg_rd(8'h20, 8'h8F);
        reg_wr(8'h1E, 8'h01);
        reg_rd(8'h20, 8'h00);
        auto_case(2'b11, 2'b01, 8'h61, 3'h3, 8'h02, 8'h02);
        reg_wr(8'h5B, 8'h23);
        auto_case(2'b01, 2'b00, 8'h32, 3'h3, 8'h02, 8'h00);
        auto_case(2'b11, 2'b11, 8'h46, 3'h3, 8'h02, 8'h02);
        reg_wr(8'h5B, 8'h24);
        auto_case(2'b11, 2'b11, 8'h61, 3'h1, 8'h04, 8'h00);
        check(24'({phy, bc}), 24'h00_0000);
        reg_rd(8'h5D, 8'h39);
        auto_case(2'b10, 2'b00, 8'h32, 3'h0, 8'h00, 8'h00);
        pll_probe(8'h40, 1'b1);
        reg_wr(8'h5B, 8'h04);
        pll_probe(8'h41, 1'b0);
        reg_rd(8'h5B, 8'h04);
        give_verdict();
    end
endmodule
